/* watchdog_supply_supervisor.sv */
`timescale 1ns/1ps
module watchdog_supply_supervisor #(
    parameter int HOLD_TICKS_P = wdsup_pkg::HOLD_TICKS,    // Supply hold-off in slow ticks
    parameter int WD_BASE_P    = wdsup_pkg::WD_BASE_TICKS, // Watchdog period at prescale 0
    parameter int FILT_P       = wdsup_pkg::GLITCH_CYCLES  // Glitch filter length
) (
    input  wire logic               clk_sys_in,             // Core clock
    input  wire logic               rst_in,                 // Hardware reset, sync high
    input  wire wdsup_pkg::sfr_req_t sfr_req_in,            // Special function register access
    input  wire logic               instr_end_in,           // Pulse at each instruction boundary
    input  wire logic               tick_in,                // Slow tick pulse
    input  wire logic               analog_supply_good_in,  // Analog comparator, 1 = above trip
    input  wire logic               digital_supply_good_in, // Digital comparator, 1 = above trip
    input  wire logic               irq_enable_priority_two_in, // Supply irq enable
    output logic [7:0]              sfr_rdata_out,          // Read data, registered
    output logic                    wd_reset_out,           // One-cycle system reset request
    output logic                    wd_irq_out,             // High-priority irq request, one cycle per timeout; held high every cycle while armed at immediate prescale
    output logic                    supply_irq_out,         // Supply monitor irq request level
    output logic [3:0]              trip_select_out         // Trip point selects to comparators
);
    import wdsup_pkg::*;

    // ------------------------------------------------------------
    // Unlock sequencing
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        UL_IDLE    = 3'b001,
        UL_PENDING = 3'b010,
        UL_OPEN    = 3'b100
    } unlock_state_t;

    unlock_state_t unlock_reg, unlock_next;
    logic [3:0]  prescale_reg;
    logic        irq_select_reg, seen_reg, arm_reg;
    logic [15:0] wd_cnt_reg;
    logic        supply_low_irq_flag_reg, sm_on_reg;
    logic [3:0]  trip_reg;
    logic [7:0]  filt_cnt_reg;
    logic [31:0] hold_cnt_reg;
    logic        filt_low_reg;

    wire wd_write  = sfr_req_in.wr && (sfr_req_in.addr == WATCHDOG_CONTROL_ADDR);
    wire sm_write  = sfr_req_in.wr && (sfr_req_in.addr == SUPPLY_MONITOR_CONTROL_ADDR);
    wire commit    = wd_write && (unlock_reg == UL_OPEN);
    wire unlock_wr = wd_write && (unlock_reg != UL_OPEN) && sfr_req_in.wdata[WD_UNLOCK_BIT];

    // A write outside the window only arms the unlock, and only with WD_UNLOCK_BIT set; nothing else lands
    always_comb begin
        unlock_next = unlock_reg;
        unique case (unlock_reg)
            UL_IDLE:    if (unlock_wr) unlock_next = UL_PENDING;
            UL_PENDING: if (instr_end_in) unlock_next = UL_OPEN;
            UL_OPEN:    if (commit || instr_end_in) unlock_next = UL_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Watchdog timing
    // ------------------------------------------------------------
    wire [15:0] wd_limit  = 16'(WD_BASE_P) << prescale_reg[2:0];
    wire        immediate = (prescale_reg == WD_PRESCALE_IMMEDIATE);
    wire        counting  = (prescale_reg < WD_PRESCALE_IMMEDIATE);
    wire        wd_expire = tick_in && (wd_cnt_reg == wd_limit - 16'h0001);
    wire        timeout   = arm_reg && (immediate || (counting && wd_expire));
    wire        sw_arm1   = commit && sfr_req_in.wdata[WD_ARM_BIT];
    wire        seen_clr  = commit && !sfr_req_in.wdata[WD_SEEN_BIT];

    // ------------------------------------------------------------
    // Supply monitor
    // ------------------------------------------------------------
    wire both_good  = analog_supply_good_in && digital_supply_good_in;
    wire hold_done  = tick_in && (hold_cnt_reg == 32'(HOLD_TICKS_P - 1));
    wire supply_low_irq_flag_hwset = sm_on_reg && filt_low_reg;
    wire supply_low_irq_flag_swclr = sm_write && !sfr_req_in.wdata[SM_IRQ_FLAG_BIT] && both_good;
    wire supply_low_irq_flag_swset = sm_write && sfr_req_in.wdata[SM_IRQ_FLAG_BIT];
    wire supply_low_irq_flag_auto  = sm_on_reg && supply_low_irq_flag_reg && both_good && hold_done;
    wire supply_low_irq_flag_next  = supply_low_irq_flag_hwset || supply_low_irq_flag_swset || (supply_low_irq_flag_reg && !supply_low_irq_flag_swclr && !supply_low_irq_flag_auto);
    wire supply_low_irq_flag_rise  = supply_low_irq_flag_next && !supply_low_irq_flag_reg;

    wire [7:0] wd_view = {prescale_reg, irq_select_reg, seen_reg, arm_reg,
                          unlock_reg == UL_OPEN};
    wire [7:0] sm_view = {digital_supply_good_in, analog_supply_good_in, supply_low_irq_flag_reg,
                          trip_reg, sm_on_reg};
    wire [7:0] rdata_next = (sfr_req_in.addr == WATCHDOG_CONTROL_ADDR)       ? wd_view :
                            (sfr_req_in.addr == SUPPLY_MONITOR_CONTROL_ADDR) ? sm_view : 8'h00;

    // ------------------------------------------------------------
    // Watchdog registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            unlock_reg     <= UL_IDLE;
            prescale_reg   <= WATCHDOG_CONTROL_RESET[7:4];
            irq_select_reg <= 1'b0;
            seen_reg       <= 1'b0;
            arm_reg        <= 1'b0;
            wd_cnt_reg     <= 16'h0000;
            wd_reset_out   <= 1'b0;
            wd_irq_out     <= 1'b0;
        end else begin
            unlock_reg <= unlock_next;
            if (commit) begin
                prescale_reg   <= sfr_req_in.wdata[7:4];
                irq_select_reg <= sfr_req_in.wdata[WD_IRQ_SELECT_BIT];
            end
            // Hardware set beats a software clear in the same cycle
            seen_reg <= timeout || (seen_reg && !seen_clr);
            if (supply_low_irq_flag_rise || (timeout && !irq_select_reg))
                arm_reg <= 1'b0;
            else if (commit)
                arm_reg <= sfr_req_in.wdata[WD_ARM_BIT];
            if (sw_arm1 || timeout || !arm_reg)
                wd_cnt_reg <= 16'h0000;
            else if (tick_in)
                wd_cnt_reg <= wd_cnt_reg + 16'h0001;
            // No global enable input: the request cannot be masked
            wd_reset_out <= timeout && !irq_select_reg;
            wd_irq_out   <= timeout && irq_select_reg;
        end
    end

    // ------------------------------------------------------------
    // Supply monitor registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            supply_low_irq_flag_reg     <= SUPPLY_MONITOR_CONTROL_RESET[SM_IRQ_FLAG_BIT];
            sm_on_reg    <= SUPPLY_MONITOR_CONTROL_RESET[SM_ON_BIT];
            trip_reg     <= SM_TRIP_RESET;
            filt_cnt_reg <= 8'h00;
            filt_low_reg <= 1'b0;
            hold_cnt_reg <= 32'h0000_0000;
        end else begin
            supply_low_irq_flag_reg <= supply_low_irq_flag_next;
            if (sm_write) begin
                sm_on_reg <= sfr_req_in.wdata[SM_ON_BIT];
                trip_reg  <= sfr_req_in.wdata[4:1];
            end
            // Low must persist FILT_P cycles before it counts
            if (!sm_on_reg || both_good) begin
                filt_cnt_reg <= 8'h00;
                filt_low_reg <= 1'b0;
            end else if (filt_cnt_reg == 8'(FILT_P - 1)) begin
                filt_low_reg <= 1'b1;
            end else begin
                filt_cnt_reg <= filt_cnt_reg + 8'h01;
            end
            if (!sm_on_reg || !both_good || !supply_low_irq_flag_reg || hold_done)
                hold_cnt_reg <= 32'h0000_0000;
            else if (tick_in)
                hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in)
            sfr_rdata_out <= 8'h00;
        else
            sfr_rdata_out <= rdata_next;
    end

    assign supply_irq_out  = supply_low_irq_flag_reg && irq_enable_priority_two_in;
    assign trip_select_out = trip_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_unlock_then_write;
        (unlock_reg == UL_PENDING) && instr_end_in ##1 wd_write;
    endsequence

    AST_TIMEOUT_RESET: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        timeout && !irq_select_reg |=> wd_reset_out && !wd_irq_out)
        else $error("timeout in reset mode gave no reset");
    AST_TIMEOUT_IRQ: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        timeout && irq_select_reg && !supply_low_irq_flag_rise |=> wd_irq_out && !wd_reset_out && arm_reg)
        else $error("timeout in irq mode gave no irq or disarmed");
    AST_SEEN_SET: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        timeout |=> seen_reg)
        else $error("timeout did not set seen flag");
    AST_SEEN_HOLD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        seen_reg && !commit |=> seen_reg)
        else $error("seen flag cleared without a write");
    AST_ARM_RESTART: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        sw_arm1 && !supply_low_irq_flag_rise && !timeout |=> arm_reg && wd_cnt_reg == 16'h0000)
        else $error("arm write did not restart counter");
    AST_SUPPLY_LOW_IRQ_FLAG_DISARM: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $rose(supply_low_irq_flag_reg) |-> !arm_reg)
        else $error("supply interrupt left watchdog armed");
    AST_UNLOCK_SEQ: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        s_unlock_then_write |-> commit)
        else $error("unlocked write not committed");
    AST_LOCKED_IGNORED: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        wd_write && unlock_reg != UL_OPEN |=> $stable(prescale_reg) && $stable(irq_select_reg))
        else $error("locked write changed control");
    AST_LOW_SETS_FLAG: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        sm_on_reg && filt_low_reg |=> supply_low_irq_flag_reg)
        else $error("filtered low supply did not set flag");
    AST_SWCLR_BLOCKED: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        supply_low_irq_flag_reg && sm_write && !both_good |=> supply_low_irq_flag_reg)
        else $error("flag cleared while supply low");
    AST_AUTO_CLEAR: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $fell(supply_low_irq_flag_reg) |-> $past(supply_low_irq_flag_swclr) || $past(hold_done) || $past(rst_in))
        else $error("flag cleared before hold-off");
    AST_GLITCH: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $rose(filt_low_reg) |-> $past(!both_good))
        else $error("filter fired on good supply");

    // ------------------------------------------------------------
    // Watchdog checks
    // ------------------------------------------------------------
    AST_CNT_BOUND: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        arm_reg && counting |-> wd_cnt_reg < wd_limit)
        else $error("watchdog count passed its period");

    AST_EXCLUSIVE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !(wd_reset_out && wd_irq_out))
        else $error("reset and irq requested together");

    AST_PULSE_ONE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        wd_reset_out |=> !wd_reset_out)
        else $error("reset request longer than one cycle");

    AST_DISARMED_QUIET: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !arm_reg |=> !wd_reset_out && !wd_irq_out)
        else $error("disarmed watchdog timed out");

    AST_RESET_DISARMS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        timeout && !irq_select_reg |=> !arm_reg)
        else $error("reset timeout left watchdog armed");

    AST_ARM_SW_CLEAR: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        commit && !sfr_req_in.wdata[WD_ARM_BIT] |=> !arm_reg)
        else $error("arm write of 0 did not disarm");

    AST_COMMIT_LANDS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        commit |=> prescale_reg == $past(sfr_req_in.wdata[7:4])
            && irq_select_reg == $past(sfr_req_in.wdata[WD_IRQ_SELECT_BIT]))
        else $error("unlocked write did not land");

    AST_UNLOCK_EXPIRE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        unlock_reg == UL_OPEN && (commit || instr_end_in) |=> unlock_reg == UL_IDLE)
        else $error("unlock window outlived one instruction");

    AST_SEEN_SW_CLEAR: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        seen_clr && !timeout |=> !seen_reg)
        else $error("write of 0 did not clear seen flag");

    // ------------------------------------------------------------
    // Supply monitor checks
    // ------------------------------------------------------------
    // Only meaningful when the filter is longer than one cycle
    sequence s_one_cycle_dip;
        (FILT_P > 1) && sm_on_reg && both_good ##1 !both_good ##1 both_good;
    endsequence

    sequence s_hold_expired;
        sm_on_reg && supply_low_irq_flag_reg && both_good && hold_done && !supply_low_irq_flag_swset && !filt_low_reg;
    endsequence

    AST_FLAG_IRQ: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        supply_low_irq_flag_reg && irq_enable_priority_two_in |-> supply_irq_out)
        else $error("enabled flag gave no interrupt");

    AST_FLAG_IRQ_MASK: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !irq_enable_priority_two_in |-> !supply_irq_out)
        else $error("disabled supply interrupt was requested");

    AST_FLAG_HELD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        supply_low_irq_flag_reg && !both_good |=> supply_low_irq_flag_reg)
        else $error("flag fell while a supply is low");

    AST_OFF_FILTER: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !sm_on_reg |=> !filt_low_reg)
        else $error("disabled monitor kept a low report");

    AST_OFF_NO_SET: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !sm_on_reg && !supply_low_irq_flag_reg && !sm_write |=> !supply_low_irq_flag_reg)
        else $error("disabled monitor raised the flag");

    AST_HOLD_RESTART: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !both_good |=> hold_cnt_reg == 32'h0000_0000)
        else $error("hold-off count survived a low supply");

    AST_HOLD_BOUND: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        hold_cnt_reg < 32'(HOLD_TICKS_P))
        else $error("hold-off count passed its end");

    AST_HOLD_CLEARS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        s_hold_expired |=> !supply_low_irq_flag_reg)
        else $error("flag outlived the hold-off");

    AST_TRIP_WRITE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        sm_write |=> trip_select_out == $past(sfr_req_in.wdata[4:1]))
        else $error("trip select write did not land");

    AST_GLITCH_SHORT: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        s_one_cycle_dip |=> !filt_low_reg)
        else $error("one-cycle dip passed the filter");

endmodule : watchdog_supply_supervisor

/* watchdog_supply_supervisor_tb_top.sv */
`timescale 1ns/1ps
module watchdog_supply_supervisor_tb_top;
    import wdsup_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and design
    // ------------------------------------------------------------
    logic       clk_sys_in;
    logic       rst_in;
    sfr_req_t   req;
    logic       instr_end;
    logic       tick;
    logic       ana_good;
    logic       dig_good;
    logic       irq_en;
    logic [7:0] rdata;
    logic       wd_rst;
    logic       wd_irq;
    logic       sup_irq;
    logic [3:0] trip;
    int         num_errors;
    int         tests_run;
    int         cycles;
    logic [7:0] irq_cnt;
    logic [7:0] rst_cnt;

    // Short counts keep the run brief; expectations below assume these values
    watchdog_supply_supervisor #(.HOLD_TICKS_P(4), .WD_BASE_P(4), .FILT_P(2))
        watchdog_supply_supervisor_inst (
        .clk_sys_in                 (clk_sys_in),
        .rst_in                     (rst_in),
        .sfr_req_in                 (req),
        .instr_end_in               (instr_end),
        .tick_in                    (tick),
        .analog_supply_good_in      (ana_good),
        .digital_supply_good_in     (dig_good),
        .irq_enable_priority_two_in (irq_en),
        .sfr_rdata_out              (rdata),
        .wd_reset_out               (wd_rst),
        .wd_irq_out                 (wd_irq),
        .supply_irq_out             (sup_irq),
        .trip_select_out            (trip)
    );

    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end

    // Pulses are counted rather than caught, since their exact cycle is the design's choice
    always @(posedge clk_sys_in) begin
        cycles++;
        if (wd_irq === 1'b1) irq_cnt++;
        if (wd_rst === 1'b1) rst_cnt++;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{addr: a, wr: 1'b1, wdata: d};
        @(posedge clk_sys_in);
        #1 req.wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        req.addr = a;
        @(posedge clk_sys_in);
        #1 check("read", rdata, exp);
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : cyc

    // Unlock, let one instruction boundary pass, then commit
    task automatic wd_write(input logic [7:0] d);
        wr(WATCHDOG_CONTROL_ADDR, 8'h01);
        instr_end = 1'b1;
        @(posedge clk_sys_in);
        #1 instr_end = 1'b0;
        wr(WATCHDOG_CONTROL_ADDR, d);
    endtask : wd_write

    task automatic tk(input int n);
        repeat (n) begin
            tick = 1'b1;
            cyc(1);
            tick = 1'b0;
            cyc(1);
        end
        cyc(3);
    endtask : tk

    task automatic summarize();
        $display("Checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        req = '0; instr_end = 0; tick = 0; ana_good = 1; dig_good = 1; irq_en = 1;
        rst_in = 1; num_errors = 0; tests_run = 0; cycles = 0; irq_cnt = 0; rst_cnt = 0;
        cyc(3);
        rst_in = 0;
        rd(SUPPLY_MONITOR_CONTROL_ADDR, 8'hDE);
        rd(WATCHDOG_CONTROL_ADDR, 8'h00);
        rd(8'h55, 8'h00);
        check("trip", {4'h0, trip}, 8'h0F);
        wr(WATCHDOG_CONTROL_ADDR, 8'h72);
        rd(WATCHDOG_CONTROL_ADDR, 8'h00);
        // Interrupt mode runs as a periodic timer and stays armed
        wd_write(8'h0A);
        tk(3);
        check("irq early", irq_cnt, 8'h00);
        tk(1);
        check("irq", irq_cnt, 8'h01);
        check("rst", rst_cnt, 8'h00);
        rd(WATCHDOG_CONTROL_ADDR, 8'h0E);
        tk(4);
        check("irq again", irq_cnt, 8'h02);
        // Reset mode, with a refresh in mid-count
        wd_write(8'h02);
        rd(WATCHDOG_CONTROL_ADDR, 8'h02);
        tk(3);
        wd_write(8'h02);
        tk(3);
        check("refresh", rst_cnt, 8'h00);
        tk(1);
        check("rst", rst_cnt, 8'h01);
        rd(WATCHDOG_CONTROL_ADDR, 8'h04);
        wd_write(8'h82);
        cyc(4);
        check("immediate", rst_cnt, 8'h02);
        rst_in = 1;
        cyc(1);
        rst_in = 0;
        rd(WATCHDOG_CONTROL_ADDR, 8'h00);
        // Supply monitor, each comparator in turn
        wr(SUPPLY_MONITOR_CONTROL_ADDR, 8'h1F);
        ana_good = 0;
        cyc(1);
        ana_good = 1;
        cyc(4);
        rd(SUPPLY_MONITOR_CONTROL_ADDR, 8'hDF);
        for (int i = 0; i < 2; i++) begin
            wd_write(8'h0A);
            if (i == 0) ana_good = 0; else dig_good = 0;
            cyc(8);
            check("sup irq", {7'h0, sup_irq}, 8'h01);
            rd(SUPPLY_MONITOR_CONTROL_ADDR, (i == 0) ? 8'hBF : 8'h7F);
            rd(WATCHDOG_CONTROL_ADDR, 8'h08);
            wr(SUPPLY_MONITOR_CONTROL_ADDR, 8'h1F);
            rd(SUPPLY_MONITOR_CONTROL_ADDR, (i == 0) ? 8'hBF : 8'h7F);
            irq_en = 0;
            cyc(1);
            check("sup irq off", {7'h0, sup_irq}, 8'h00);
            irq_en = 1;
            ana_good = 1;
            dig_good = 1;
            cyc(4);
            tk(3);
            rd(SUPPLY_MONITOR_CONTROL_ADDR, 8'hFF);
            tk(2);
            rd(SUPPLY_MONITOR_CONTROL_ADDR, 8'hDF);
        end
        // A dip during the hold-off restarts it
        ana_good = 0;
        cyc(4);
        ana_good = 1;
        tk(3);
        ana_good = 0;
        cyc(1);
        ana_good = 1;
        tk(3);
        rd(SUPPLY_MONITOR_CONTROL_ADDR, 8'hFF);
        tk(1);
        rd(SUPPLY_MONITOR_CONTROL_ADDR, 8'hDF);
        // Disabled monitor ignores a long low supply
        wr(SUPPLY_MONITOR_CONTROL_ADDR, 8'h08);
        ana_good = 0;
        cyc(8);
        rd(SUPPLY_MONITOR_CONTROL_ADDR, 8'h88);
        check("trip", {4'h0, trip}, 8'h04);
        summarize();
    end
endmodule : watchdog_supply_supervisor_tb_top

/* wdsup_pkg.sv */
package wdsup_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] SUPPLY_MONITOR_CONTROL_ADDR  = 8'hDF;
    localparam logic [7:0] SUPPLY_MONITOR_CONTROL_RESET = 8'hDE;
    localparam logic [7:0] WATCHDOG_CONTROL_ADDR        = 8'hC0;
    localparam logic [7:0] WATCHDOG_CONTROL_RESET       = 8'h00;

    // ------------------------------------------------------------
    // Watchdog control fields
    // ------------------------------------------------------------
    localparam int WD_PRESCALE_LSB   = 4;
    localparam int WD_IRQ_SELECT_BIT = 3;
    localparam int WD_SEEN_BIT       = 2;
    localparam int WD_ARM_BIT        = 1;
    localparam int WD_UNLOCK_BIT     = 0;
    localparam logic [3:0] WD_PRESCALE_IMMEDIATE = 4'h8;

    // ------------------------------------------------------------
    // Supply monitor control fields
    // ------------------------------------------------------------
    localparam int SM_DIGITAL_GOOD_BIT = 7;
    localparam int SM_ANALOG_GOOD_BIT  = 6;
    localparam int SM_IRQ_FLAG_BIT     = 5;
    localparam int SM_TRIP_LSB         = 1;
    localparam int SM_ON_BIT           = 0;
    localparam logic [3:0] SM_TRIP_RESET = 4'hF;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int GLITCH_TIME_NS  = 100;
    localparam int GLITCH_CYCLES   = (GLITCH_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_TIME_MS    = 250;
    localparam int TICK_RATE_HZ    = 32768;
    localparam int HOLD_TICKS      = (HOLD_TIME_MS * TICK_RATE_HZ + 999) / 1000;
    localparam int WD_BASE_TICKS   = 16;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
    } sfr_req_t;

endpackage : wdsup_pkg
